/* File: src/rpf_map.svh */
/*
  address map, field positions, reset values and function codes
  of the reserved pin function selector.
  assumes: included by the package and the design, APB byte addresses.
*/
`ifndef RPF_MAP_SVH
`define RPF_MAP_SVH
// register byte offsets
`define RPF_OFS_FUNC 8'h00
`define RPF_OFS_CTRL 8'h04
`define RPF_OFS_STAT 8'h08
`define RPF_OFS_ISTS 8'h0C
`define RPF_OFS_IMSK 8'h10
// reset values
`define RPF_FUNC_RST 32'h0000_0000
`define RPF_CTRL_RST 5'h00
`define RPF_IMSK_RST 5'h00
// control bits: which pin functions are chosen as source
`define RPF_CTRL_EN 0
`define RPF_CTRL_PLS 1
`define RPF_CTRL_GEN 2
`define RPF_CTRL_SEQ 3
`define RPF_CTRL_CUR 4
// interrupt status bits
`define RPF_EV_GEN 0
`define RPF_EV_UPD 1
`define RPF_EV_START 2
`define RPF_EV_DONE 3
`define RPF_EV_REJ 4
// function codes, one nibble per pin
`define RPF_F_NONE 4'h0
`define RPF_F_EN 4'h1
`define RPF_F_PLS 4'h2
`define RPF_F_PTRIG 4'h3
`define RPF_F_GEN 4'h4
`define RPF_F_RUN 4'h5
`define RPF_F_OK 4'h6
`define RPF_F_ERR 4'h7
`define RPF_F_ANA 4'h8
`define RPF_F_UPD 4'h9
`define RPF_F_SEQ 4'hA
`endif

/* File: src/rpf_pkg.sv */
/*
  types of the reserved pin function selector.
  assumes: rpf_map.svh holds the numbers.
*/
`include "rpf_map.svh"
package rpf_pkg;
  // pin function codes
  typedef enum logic [3:0] {
    RPF_NONE = `RPF_F_NONE,
    RPF_EN = `RPF_F_EN,
    RPF_PLS = `RPF_F_PLS,
    RPF_PTRIG = `RPF_F_PTRIG,
    RPF_GEN = `RPF_F_GEN,
    RPF_RUN = `RPF_F_RUN,
    RPF_OK = `RPF_F_OK,
    RPF_ERR = `RPF_F_ERR,
    RPF_ANA = `RPF_F_ANA,
    RPF_UPD = `RPF_F_UPD,
    RPF_SEQ = `RPF_F_SEQ
  } rpf_func_e;
  // the eight connector pins as a group
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] pd;
    logic [7:0] ana;
  } rpf_pins_s;
  // whole state of the selector
  typedef struct packed {
    logic [31:0] func;
    logic [4:0] ctrl;
    logic [4:0] imsk;
    logic [4:0] ists;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] pout;
    logic en;
    logic shrt;
    logic gen;
    logic upd;
    logic start;
    logic seq_act;
    logic [31:0] rdata;
  } rpf_state_s;
endpackage

/* File: src/rpf_top.sv */
/*
  reserved pin function selector: eight connector pins, each with a
  software chosen function, APB register access, one interrupt.
  assumes: pclk 250 MHz, presetn async active low, driver status and
  pulse state inputs come from logic on pclk; pads add pulls and
  the tri-state buffer from pin_s.
*/
// Functional notes
// - each of eight pins configured independently
// - no function leaves pin high impedance
// - enable input high enables, pull-down
// - enable, pulse, pulse-trigger only on pins 5-8
// - pulse input low shorts output, pull-down
// - pulse-trigger output mirrors output pulse state
// - generator trigger rising edge resets generator
// - run indicator high while in run
// - ok indicator high in ready or run
// - error indicator high otherwise
// - no status indicators on pin 8
// - analog current input only pins 3-4
// - update rising edge loads new current
// - sequence falling edge starts, pull-up
// - after sequence disable output, rearm
`include "rpf_map.svh"
module rpf_top (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // connector pins
  input wire logic [7:0] pin_in,
  output rpf_pkg::rpf_pins_s pin_s,
  // driver side status
  input wire logic drv_run,
  input wire logic drv_ready,
  input wire logic pulse_state,
  input wire logic seq_done,
  // driver side controls
  output logic drv_enable,
  output logic out_short,
  output logic gen_reset,
  output logic cur_load,
  output logic seq_start,
  output logic seq_out_en,
  // interrupt
  output logic irq
);

  // legality of a function code on a pin index 0..7
  function automatic logic fn_legal(input int unsigned idx, input logic [3:0] c);
    logic ok;
    ok = 1'b0;
    case (c)
      `RPF_F_NONE, `RPF_F_GEN, `RPF_F_UPD, `RPF_F_SEQ: ok = 1'b1;
      // gate and pulse feedback only on upper four
      `RPF_F_EN, `RPF_F_PLS, `RPF_F_PTRIG: ok = (idx >= 4);
      // no status indicator on last pin
      `RPF_F_RUN, `RPF_F_OK, `RPF_F_ERR: ok = (idx != 7);
      // analog input on third and fourth pin
      `RPF_F_ANA: ok = (idx == 2) || (idx == 3);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // mask of pins holding a given function
  function automatic logic [7:0] fn_pins(input logic [31:0] f, input logic [3:0] c);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      m[i] = (f[4*i+:4] == c);
    end
    return m;
  endfunction

  // whole block state as one struct
  rpf_pkg::rpf_state_s q; // registered state
  rpf_pkg::rpf_state_s d; // next state

  // decoded views of the synchronised pins
  logic [7:0] rise; // synchronised rising edges
  logic [7:0] fall; // synchronised falling edges
  logic [7:0] en_pins;
  logic [7:0] pls_pins;
  logic [7:0] gen_pins;
  logic [7:0] upd_pins;
  logic [7:0] seq_pins;
  // register access decode
  logic [31:0] func_new; // checked function word
  logic rej; // some nibble refused
  logic setup; // apb setup cycle
  logic wr; // apb write taking effect
  logic mapped; // address hits a register
  logic [4:0] ev; // events of this cycle
  logic run_ok; // ready or run

  // apb handshake: no wait state, read data flop loaded in setup
  assign setup = psel && !penable;
  assign pready = psel && penable;
  assign mapped = (paddr == `RPF_OFS_FUNC) || (paddr == `RPF_OFS_CTRL)
    || (paddr == `RPF_OFS_STAT) || (paddr == `RPF_OFS_ISTS)
    || (paddr == `RPF_OFS_IMSK);
  assign pslverr = pready && !mapped;
  assign wr = pready && pwrite && mapped;
  assign prdata = q.rdata;

  // edges from second and third flop only
  assign rise = q.s2 & ~q.s3;
  assign fall = ~q.s2 & q.s3;
  assign run_ok = drv_run || drv_ready;

  // function masks
  assign en_pins = fn_pins(q.func, `RPF_F_EN);
  assign pls_pins = fn_pins(q.func, `RPF_F_PLS);
  assign gen_pins = fn_pins(q.func, `RPF_F_GEN);
  assign upd_pins = fn_pins(q.func, `RPF_F_UPD);
  assign seq_pins = fn_pins(q.func, `RPF_F_SEQ);

  // per pin check of a function write, refused nibble keeps old code
  always_comb
  begin
    func_new = q.func;
    rej = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (fn_legal(i, pwdata[4*i+:4]))
      begin
        func_new[4*i+:4] = pwdata[4*i+:4];
      end
      else
      begin
        rej = 1'b1;
      end
    end
  end

  // next state, events of the cycle included
  always_comb
  begin
    d = q;
    // two flop synchroniser plus edge history
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // enable follows high level of chosen pin
    d.en = q.ctrl[`RPF_CTRL_EN] && |(q.s2 & en_pins);
    // low pulse input shorts the output
    d.shrt = q.ctrl[`RPF_CTRL_PLS] && |(~q.s2 & pls_pins);
    // one pulse per rising edge
    d.gen = q.ctrl[`RPF_CTRL_GEN] && |(rise & gen_pins);
    d.upd = q.ctrl[`RPF_CTRL_CUR] && |(rise & upd_pins);
    // falling edge starts only when idle
    d.start = q.ctrl[`RPF_CTRL_SEQ] && |(fall & seq_pins)
      && !q.seq_act;
    // sequence ends, output off, rearmed
    if (d.start)
    begin
      d.seq_act = 1'b1;
    end
    else if (seq_done)
    begin
      d.seq_act = 1'b0;
    end
    // events raised this cycle, gen, update and start taken from the new pulses
    ev = 5'h00;
    ev[`RPF_EV_GEN] = d.gen;
    ev[`RPF_EV_UPD] = d.upd;
    ev[`RPF_EV_START] = d.start;
    ev[`RPF_EV_DONE] = q.seq_act && seq_done;
    ev[`RPF_EV_REJ] = wr && (paddr == `RPF_OFS_FUNC) && rej;
    // output pins
    for (int i = 0; i < 8; i++)
    begin
      case (q.func[4*i+:4])
        `RPF_F_PTRIG: d.pout[i] = pulse_state;
        `RPF_F_RUN: d.pout[i] = drv_run;
        `RPF_F_OK: d.pout[i] = run_ok;
        `RPF_F_ERR: d.pout[i] = !run_ok;
        default: d.pout[i] = 1'b0;
      endcase
    end
    // register writes
    if (wr)
    begin
      unique case (paddr)
        `RPF_OFS_FUNC: d.func = func_new;
        `RPF_OFS_CTRL: d.ctrl = pwdata[4:0];
        `RPF_OFS_IMSK: d.imsk = pwdata[4:0];
        default: d.ctrl = q.ctrl;
      endcase
    end
    // sticky status, set wins over write-one clear
    if (wr && (paddr == `RPF_OFS_ISTS))
    begin
      d.ists = (q.ists & ~pwdata[4:0]) | ev;
    end
    else
    begin
      d.ists = q.ists | ev;
    end
    // read data caught in setup cycle
    if (setup)
    begin
      case (paddr)
        `RPF_OFS_FUNC: d.rdata = q.func;
        `RPF_OFS_CTRL: d.rdata = {27'h0, q.ctrl};
        `RPF_OFS_STAT: d.rdata = {21'h0, q.seq_act, q.shrt, q.en, q.s2};
        `RPF_OFS_ISTS: d.rdata = {27'h0, q.ists};
        `RPF_OFS_IMSK: d.rdata = {27'h0, q.imsk};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.func <= `RPF_FUNC_RST;
      q.ctrl <= `RPF_CTRL_RST;
      q.imsk <= `RPF_IMSK_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // pin drive, pulls and analog routing
  always_comb
  begin
    pin_s.o = q.pout;
    // driven only for output functions
    pin_s.oe = fn_pins(q.func, `RPF_F_PTRIG) | fn_pins(q.func, `RPF_F_RUN)
      | fn_pins(q.func, `RPF_F_OK) | fn_pins(q.func, `RPF_F_ERR);
    // weak pulls for logic inputs
    pin_s.pd = en_pins | pls_pins | gen_pins | upd_pins;
    pin_s.pu = seq_pins;
    pin_s.ana = fn_pins(q.func, `RPF_F_ANA);
  end

  // driver controls from flops
  assign drv_enable = q.en;
  assign out_short = q.shrt;
  assign gen_reset = q.gen;
  assign cur_load = q.upd;
  assign seq_start = q.start;
  // output allowed unless single sequence mode is idle
  assign seq_out_en = !q.ctrl[`RPF_CTRL_SEQ] || q.seq_act;
  // level interrupt from unmasked sticky bits
  assign irq = |(q.ists & q.imsk);

  // helper for assertions
  logic [7:0] run_pins;
  logic func_ok;
  logic [7:0] ptrig_pins; // pulse trigger pins
  logic [7:0] ok_pins; // ok indicator pins
  logic [7:0] err_pins; // error indicator pins
  assign run_pins = fn_pins(q.func, `RPF_F_RUN);
  assign ptrig_pins = fn_pins(q.func, `RPF_F_PTRIG);
  assign ok_pins = fn_pins(q.func, `RPF_F_OK);
  assign err_pins = fn_pins(q.func, `RPF_F_ERR);
  always_comb
  begin
    func_ok = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      func_ok = func_ok && fn_legal(i, q.func[4*i+:4]);
    end
  end

  // one cycle pulse shape
  sequence one_pulse(sig);
    sig ##1 !sig;
  endsequence

  // every stored nibble is legal for its pin
  chk_func_legal: assert property (@(posedge pclk) disable iff (!presetn)
    func_ok)
    else $error("illegal function code stored");

  // a pin without function is never driven
  chk_none_hiz: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_s.oe & fn_pins(q.func, `RPF_F_NONE)) == 8'h00)
    else $error("unused pin driven");

  // a chosen rising edge gives exactly one reset pulse
  chk_gen_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (q.ctrl[`RPF_CTRL_GEN] && |(rise & gen_pins)) |=> one_pulse(gen_reset))
    else $error("generator reset not one pulse after edge");

  // load pulse only after a gated rising edge
  chk_upd_edge: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cur_load) |-> $past(q.ctrl[`RPF_CTRL_CUR]) && $past(|(rise & upd_pins)))
    else $error("current load without rising edge");

  // start only from idle, output on at once
  chk_seq_start: assert property (@(posedge pclk) disable iff (!presetn)
    seq_start |-> seq_out_en && !$past(q.seq_act))
    else $error("sequence start while busy");

  // end of a sequence switches the output off
  chk_seq_done: assert property (@(posedge pclk) disable iff (!presetn)
    (q.seq_act && seq_done && !d.start && q.ctrl[`RPF_CTRL_SEQ])
    |=> !seq_out_en)
    else $error("output left on after sequence");

  // run pin follows run status one cycle late
  chk_run_pin: assert property (@(posedge pclk) disable iff (!presetn)
    ((pin_s.o ^ {8{$past(drv_run)}}) & run_pins & $past(run_pins)) == 8'h00)
    else $error("run indicator wrong");

  // enable rises only three edges after a high pin
  chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(drv_enable) |-> $past(pin_in & en_pins, 3) != 8'h00)
    else $error("enable not from synchronised pin");

  // a pin is never pulled both ways
  chk_pull_excl: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_s.pu & pin_s.pd) == 8'h00)
    else $error("pull up and down together");

  // pulse trigger pin follows pulse state one cycle late
  chk_ptrig_pin: assert property (@(posedge pclk) disable iff (!presetn)
    ((pin_s.o ^ {8{$past(pulse_state)}}) & ptrig_pins & $past(ptrig_pins)) == 8'h00)
    else $error("pulse trigger pin wrong");

  // ok pin high in ready or run
  chk_ok_pin: assert property (@(posedge pclk) disable iff (!presetn)
    ((pin_s.o ^ {8{$past(drv_run || drv_ready)}}) & ok_pins & $past(ok_pins)) == 8'h00)
    else $error("ok indicator wrong");

  // error pin high outside ready and run
  chk_err_pin: assert property (@(posedge pclk) disable iff (!presetn)
    ((pin_s.o ^ {8{!$past(drv_run || drv_ready)}}) & err_pins & $past(err_pins)) == 8'h00)
    else $error("error indicator wrong");

  // short rises only three edges after a low pulse pin
  chk_short_sync: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(out_short) |-> ($past(~pin_in, 3) & $past(pls_pins)) != 8'h00)
    else $error("short not from synchronised low pin");

  // no generator reset without its source chosen
  chk_gen_gate: assert property (@(posedge pclk) disable iff (!presetn)
    gen_reset |-> $past(q.ctrl[`RPF_CTRL_GEN]))
    else $error("generator reset without source");

  // no start while a sequence runs
  chk_seq_busy: assert property (@(posedge pclk) disable iff (!presetn)
    q.seq_act |=> !seq_start)
    else $error("sequence restarted while busy");

  // no start without single sequence chosen
  chk_start_gate: assert property (@(posedge pclk) disable iff (!presetn)
    seq_start |-> $past(q.ctrl[`RPF_CTRL_SEQ]))
    else $error("sequence start without source");

  // no enable without the pin chosen as source
  chk_en_gate: assert property (@(posedge pclk) disable iff (!presetn)
    drv_enable |-> $past(q.ctrl[`RPF_CTRL_EN]))
    else $error("enable without source");

  // a refused nibble raises the reject flag
  chk_rej_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && (paddr == `RPF_OFS_FUNC) && rej) |=> q.ists[`RPF_EV_REJ])
    else $error("refused write not flagged");

endmodule

/* File: tb/rpf_ext.sv */
/*
  external control system model: drives and samples the eight pins.
  assumes: pin_s comes from rpf_top, drive requests from the bench.
*/
module rpf_ext (
  // clock
  input wire logic pclk,
  // device side
  input wire rpf_pkg::rpf_pins_s pin_s,
  output logic [7:0] pin_in,
  // bench requests
  input wire logic [7:0] drv,
  input wire logic [7:0] drv_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tog_q = 8'h55; // level of a floating pin
  // a floating pin changes every cycle
  always @(posedge pclk)
    tog_q <= ~tog_q;
  // wire level: device drive, our drive, pulls, else floating
  always_comb
    for (int i = 0; i < 8; i++)
      if (pin_s.oe[i])
        pin_in[i] = pin_s.o[i];
      else if (drv_en[i])
        pin_in[i] = drv[i];
      else if (pin_s.pu[i])
        pin_in[i] = 1'b1;
      else if (pin_s.pd[i])
        pin_in[i] = 1'b0;
      else
        pin_in[i] = tog_q[i];
endmodule

/* File: tb/testbench.sv */
/*
  testbench of the reserved pin function selector: apb tasks, pin
  stimulus through the external model, pulse counters.
  assumes: rpf_top and rpf_ext, pclk 4 ns, reset held 2 cycles.
*/
`include "rpf_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, drv = 8'h00, drv_en = 8'h00, pin_in;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, drv_run = 0, drv_ready = 0, pulse_state = 0;
  logic seq_done = 0, drv_enable, out_short, gen_reset, cur_load;
  logic seq_start, seq_out_en, irq;
  rpf_pkg::rpf_pins_s pin_s;
  int errors = 0, n_tests = 0, cycles = 0, n_gen = 0, n_cur = 0, n_seq = 0;
  // 250 MHz clock
  always #2 pclk = ~pclk;
  rpf_top u_rpf_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_s(pin_s), .drv_run(drv_run), .drv_ready(drv_ready),
    .pulse_state(pulse_state), .seq_done(seq_done), .drv_enable(drv_enable),
    .out_short(out_short), .gen_reset(gen_reset), .cur_load(cur_load),
    .seq_start(seq_start), .seq_out_en(seq_out_en), .irq(irq));
  rpf_ext u_rpf_ext (.pclk(pclk), .pin_s(pin_s), .pin_in(pin_in),
    .drv(drv), .drv_en(drv_en));
  // count action pulses and bound the run
  always @(posedge pclk)
  begin
    if (gen_reset === 1'b1) n_gen <= n_gen + 1;
    if (cur_load === 1'b1) n_cur <= n_cur + 1;
    if (seq_start === 1'b1) n_seq <= n_seq + 1;
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      conclude();
    end
  end
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // drive one pin from the far side
  task automatic pin(input int i, input logic v);
    @(posedge pclk);
    drv[i] <= v;
    drv_en[i] <= 1'b1;
    cyc(7);
  endtask
  // verdict
  task automatic conclude;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // main sequence
  initial
  begin
    cyc(2);
    chk(pin_s.oe, 0); // all pins released
    chk(seq_out_en, 1);
    presetn <= 1'b1;
    apb(1, `RPF_OFS_FUNC, 32'h5000_0B81);
    apb(0, `RPF_OFS_FUNC, 0);
    chk(rd, 0); // misplaced codes refused
    apb(0, `RPF_OFS_ISTS, 0);
    chk(rd, 32'h10); // reject flagged
    apb(1, `RPF_OFS_FUNC, 32'h3421_7865);
    apb(0, `RPF_OFS_FUNC, 0);
    chk(rd, 32'h3421_7865); // each pin on its own
    chk(pin_s.oe, 8'h8B); // outputs drive, inputs float
    chk(pin_s.ana, 8'h04); // analog routed
    chk(pin_s.pd, 8'h70); // input pulls
    for (int k = 0; k < 8; k++)
    begin
      @(posedge pclk);
      {pulse_state, drv_run, drv_ready} <= k[2:0];
      cyc(4);
      chk(pin_s.o & 8'h8B, {k[2], 3'b0, ~|k[1:0], 1'b0, |k[1:0], k[1]});
    end
    apb(1, `RPF_OFS_CTRL, 32'h07);
    cyc(6);
    chk(drv_enable, 0); // pulled low, disabled
    chk(out_short, 1); // pulled low, shorted
    pin(4, 1);
    pin(5, 1);
    chk(drv_enable, 1);
    chk(out_short, 0);
    apb(0, `RPF_OFS_STAT, 0);
    chk(rd & 32'h0000_07FB, 32'h0000_01B3); // synced pins and enable
    apb(0, `RPF_OFS_CTRL, 0);
    chk(rd, 32'h0000_0007); // sources kept
    pin(6, 1);
    chk(n_gen, 1); // one reset per rise
    pin(6, 0);
    pin(6, 1);
    chk(n_gen, 2);
    apb(0, `RPF_OFS_ISTS, 0);
    chk(rd, 32'h11);
    chk(irq, 0); // masked
    apb(1, `RPF_OFS_IMSK, 32'h01);
    apb(0, `RPF_OFS_IMSK, 0);
    chk(rd, 32'h0000_0001);
    cyc(1);
    chk(irq, 1);
    apb(1, `RPF_OFS_ISTS, 32'h01);
    cyc(1);
    chk(irq, 0); // cleared
    apb(1, 8'h14, 32'hFFFF_FFFF);
    chk(se, 1);
    apb(0, 8'h14, 0);
    chk(rd, 0);
    chk(se, 1);
    @(posedge pclk);
    drv_en <= 8'h00;
    apb(1, `RPF_OFS_FUNC, 32'h0000_05A9);
    cyc(1);
    chk(pin_s.pu, 8'h02); // sequence pin pulled up
    chk(pin_s.pd, 8'h01); // update pin pulled down
    chk(pin_s.oe, 8'h04); // run pin driven
    apb(1, `RPF_OFS_CTRL, 32'h18);
    cyc(6);
    chk(seq_out_en, 0); // idle, output off
    pin(0, 1);
    chk(n_cur, 1); // load on rise
    pin(1, 0);
    chk(n_seq, 1); // start on fall
    chk(seq_out_en, 1);
    pin(1, 1);
    pin(1, 0);
    chk(n_seq, 1); // busy, fall ignored
    pin(1, 1);
    @(posedge pclk);
    seq_done <= 1'b1;
    @(posedge pclk);
    seq_done <= 1'b0;
    cyc(2);
    chk(seq_out_en, 0); // output off after one run
    pin(1, 0);
    chk(n_seq, 2); // restart allowed
    apb(0, `RPF_OFS_ISTS, 0);
    chk(rd, 32'h1E);
    apb(1, `RPF_OFS_FUNC, 0);
    cyc(1);
    chk(pin_s.oe, 0);
    conclude();
  end
endmodule
